// File: rtl/csim_map.svh
`ifndef CSIM_MAP_SVH
`define CSIM_MAP_SVH
// register indices; the byte address on the bus is 4 x index
`define CSIM_IDX_STATUS 16'h0D01
`define CSIM_IDX_EV_LOOP 16'h0D02
`define CSIM_IDX_EV_SYS 16'h0D03
`define CSIM_IDX_EV_DIG 16'h0D04
`define CSIM_IDX_EV_HIST 16'h0D05
`define CSIM_IDX_UPDATE 16'h0005
`define CSIM_IDX_MASK_LOOP 16'h0209
`define CSIM_IDX_MASK_SYS 16'h020A
`define CSIM_IDX_MASK_DIG 16'h020B
`define CSIM_IDX_MASK_HIST 16'h020C
`define CSIM_IDX_CLR_ALL 16'h0A03
`define CSIM_IDX_CLR_LOOP 16'h0A04
`define CSIM_IDX_CLR_SYS 16'h0A05
`define CSIM_IDX_CLR_DIG 16'h0A06
`define CSIM_IDX_CLR_HIST 16'h0A07
// fields
`define CSIM_CLR_ALL_BIT 1
`define CSIM_UPDATE_VAL 8'h01
`define CSIM_LOOP_EV_MASK 8'h3F
`define CSIM_SYS_EV_MASK 8'h1F
`define CSIM_DIG_EV_MASK 8'hFF
`define CSIM_HIST_EV_MASK 8'h1F
`define CSIM_STATUS_MASK 8'h7F
// reset values
`define CSIM_MASK_RST 8'h00
`define CSIM_EV_RST 8'h00
`endif

// File: rtl/csim_pkg.sv
package csim_pkg;
   // raw condition levels from the loops and their pulse events
   typedef struct packed {
      logic sys_loop_locked;
      logic sys_clk_stable;
      logic output_analog_locked;
      logic output_cal_busy;
      logic output_osc_ok;
      logic digital_loop_locked;
      logic freq_locked;
      logic phase_locked;
      logic freq_clamped;
      logic slew_limiting;
   } csim_levels_s;

   typedef struct packed {
      logic rom_load_done;
      logic dist_sync;
      logic watchdog_expired;
      logic nvm_fault;
      logic nvm_done;
      logic ref_switch;
      logic enter_closed;
      logic enter_freerun;
      logic enter_holdover;
      logic history_update;
   } csim_pulses_s;

   typedef enum logic [1:0] {
      CSIM_IDLE = 2'b00,
      CSIM_DATA = 2'b01
   } csim_phase_e;
endpackage

// File: rtl/csim_monitor.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`include "csim_map.svh"
// Summary of operation
// - status bit 6: digital and output analog loops both locked
// - status bit 5: system, output analog and digital loops all locked
// - status bit 4: output oscillator running correctly
// - status bit 3: high throughout output oscillator calibration
// - status bit 2: output analog loop lock state
// - status bit 1: system clock stability timer expired
// - status bit 0: system clock loop lock detector
// - unmasked event sets its monitor bit, which stays set
// - monitor bits clear only by clear bit, clear-all, or reset; reads do not
// - bit 5 on system loop unlock, bit 4 on lock
// - bit 3 on output loop unlock, bit 2 on lock
// - bit 0 on calibration start, bit 1 on calibration end
// - bit 4 ROM load done, bit 3 distribution sync, bit 2 watchdog
// - bit 1 nonvolatile fault, bit 0 nonvolatile success
// - bits 7..4: reference switch, closed loop, free run, holdover
// - bits 3..0: frequency unlock/lock, phase unlock/lock
// - history register bit 4 on tuning word history update
// - bit 3 leaving clamp, bit 2 entering clamp
// - bit 1 slew limiting stops, bit 0 slew limiting starts
// - status read-only; update write of 0x01 captures latest status
module csim_monitor
   import csim_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [17:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // loop conditions and events
   input wire csim_levels_s levels_i,
   input wire csim_pulses_s pulses_i
);

   ////////////////////////////////////////////////////////////////////////////
   // address phase capture
   logic wr_pend;
   logic [15:0] wr_idx;
   logic [7:0] rd_data;
   logic addr_ok;
   csim_phase_e phase;
   logic [15:0] a_idx;

   assign a_idx = haddr_i[17:2];
   assign addr_ok = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_pend <= 1'b0;
         wr_idx <= 16'h0000;
         phase <= CSIM_IDLE;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite_i;
         phase <= addr_ok ? CSIM_DATA : CSIM_IDLE;
         if (addr_ok)
         begin
            wr_idx <= a_idx;
         end
      end
   end

   // zero wait states, always OKAY
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
      else
      begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write decode
   logic [7:0] wbyte;
   logic upd_stb;
   logic clr_all;
   logic [7:0] clr_loop;
   logic [7:0] clr_sys;
   logic [7:0] clr_dig;
   logic [7:0] clr_hist;

   assign wbyte = hwdata_i[7:0];
   assign upd_stb = wr_pend && (wr_idx == `CSIM_IDX_UPDATE) && (wbyte == `CSIM_UPDATE_VAL);
   assign clr_all = wr_pend && (wr_idx == `CSIM_IDX_CLR_ALL) && wbyte[`CSIM_CLR_ALL_BIT];
   assign clr_loop = (wr_pend && wr_idx == `CSIM_IDX_CLR_LOOP) ? wbyte : 8'h00;
   assign clr_sys = (wr_pend && wr_idx == `CSIM_IDX_CLR_SYS) ? wbyte : 8'h00;
   assign clr_dig = (wr_pend && wr_idx == `CSIM_IDX_CLR_DIG) ? wbyte : 8'h00;
   assign clr_hist = (wr_pend && wr_idx == `CSIM_IDX_CLR_HIST) ? wbyte : 8'h00;

   // mask registers: a 1 suppresses the event
   logic [7:0] mask_loop;
   logic [7:0] mask_sys;
   logic [7:0] mask_dig;
   logic [7:0] mask_hist;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         mask_loop <= `CSIM_MASK_RST;
         mask_sys <= `CSIM_MASK_RST;
         mask_dig <= `CSIM_MASK_RST;
         mask_hist <= `CSIM_MASK_RST;
      end
      else if (wr_pend)
      begin
         if (wr_idx == `CSIM_IDX_MASK_LOOP)
            mask_loop <= wbyte & `CSIM_LOOP_EV_MASK;
         if (wr_idx == `CSIM_IDX_MASK_SYS)
            mask_sys <= wbyte & `CSIM_SYS_EV_MASK;
         if (wr_idx == `CSIM_IDX_MASK_DIG)
            mask_dig <= wbyte & `CSIM_DIG_EV_MASK;
         if (wr_idx == `CSIM_IDX_MASK_HIST)
            mask_hist <= wbyte & `CSIM_HIST_EV_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on level conditions
   csim_levels_s lv_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         lv_q <= '0;
      else
         lv_q <= levels_i;
   end

   logic [7:0] raw_loop;
   logic [7:0] raw_sys;
   logic [7:0] raw_dig;
   logic [7:0] raw_hist;

   always_comb
   begin
      raw_loop = 8'h00;
      raw_loop[5] = lv_q.sys_loop_locked && !levels_i.sys_loop_locked;
      raw_loop[4] = !lv_q.sys_loop_locked && levels_i.sys_loop_locked;
      raw_loop[3] = lv_q.output_analog_locked && !levels_i.output_analog_locked;
      raw_loop[2] = !lv_q.output_analog_locked && levels_i.output_analog_locked;
      raw_loop[1] = lv_q.output_cal_busy && !levels_i.output_cal_busy;
      raw_loop[0] = !lv_q.output_cal_busy && levels_i.output_cal_busy;
   end

   always_comb
   begin
      raw_sys = 8'h00;
      raw_sys[4] = pulses_i.rom_load_done;
      raw_sys[3] = pulses_i.dist_sync;
      raw_sys[2] = pulses_i.watchdog_expired;
      raw_sys[1] = pulses_i.nvm_fault;
      raw_sys[0] = pulses_i.nvm_done;
   end

   always_comb
   begin
      raw_dig = 8'h00;
      raw_dig[7] = pulses_i.ref_switch;
      raw_dig[6] = pulses_i.enter_closed;
      raw_dig[5] = pulses_i.enter_freerun;
      raw_dig[4] = pulses_i.enter_holdover;
      raw_dig[3] = lv_q.freq_locked && !levels_i.freq_locked;
      raw_dig[2] = !lv_q.freq_locked && levels_i.freq_locked;
      raw_dig[1] = lv_q.phase_locked && !levels_i.phase_locked;
      raw_dig[0] = !lv_q.phase_locked && levels_i.phase_locked;
   end

   always_comb
   begin
      raw_hist = 8'h00;
      raw_hist[4] = pulses_i.history_update;
      raw_hist[3] = lv_q.freq_clamped && !levels_i.freq_clamped;
      raw_hist[2] = !lv_q.freq_clamped && levels_i.freq_clamped;
      raw_hist[1] = lv_q.slew_limiting && !levels_i.slew_limiting;
      raw_hist[0] = !lv_q.slew_limiting && levels_i.slew_limiting;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky monitor bits; a new event wins over a clear in the same cycle
   logic [7:0] ev_loop;
   logic [7:0] ev_sys;
   logic [7:0] ev_dig;
   logic [7:0] ev_hist;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         ev_loop <= `CSIM_EV_RST;
         ev_sys <= `CSIM_EV_RST;
         ev_dig <= `CSIM_EV_RST;
         ev_hist <= `CSIM_EV_RST;
      end
      else
      begin
         // set unless masked, clear only by clear writes
         ev_loop <= ((ev_loop & ~(clr_loop | {8{clr_all}})) | (raw_loop & ~mask_loop))
                    & `CSIM_LOOP_EV_MASK;
         ev_sys <= ((ev_sys & ~(clr_sys | {8{clr_all}})) | (raw_sys & ~mask_sys))
                   & `CSIM_SYS_EV_MASK;
         ev_dig <= ((ev_dig & ~(clr_dig | {8{clr_all}})) | (raw_dig & ~mask_dig))
                   & `CSIM_DIG_EV_MASK;
         ev_hist <= ((ev_hist & ~(clr_hist | {8{clr_all}})) | (raw_hist & ~mask_hist))
                    & `CSIM_HIST_EV_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live status, captured into the readable copy on update
   logic [7:0] live_status;
   logic [7:0] status;

   always_comb
   begin
      live_status = 8'h00;
      live_status[6] = levels_i.digital_loop_locked && levels_i.output_analog_locked;
      live_status[5] = levels_i.sys_loop_locked && levels_i.output_analog_locked
                       && levels_i.digital_loop_locked;
      live_status[4] = levels_i.output_osc_ok;
      live_status[3] = levels_i.output_cal_busy;
      live_status[2] = levels_i.output_analog_locked;
      live_status[1] = levels_i.sys_clk_stable;
      live_status[0] = levels_i.sys_loop_locked;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         status <= 8'h00;
      else if (upd_stb)
         status <= live_status & `CSIM_STATUS_MASK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; data registered in the address phase, presented in data phase
   always_comb
   begin
      unique case (a_idx)
         `CSIM_IDX_STATUS: rd_data = status;
         `CSIM_IDX_EV_LOOP: rd_data = ev_loop;
         `CSIM_IDX_EV_SYS: rd_data = ev_sys;
         `CSIM_IDX_EV_DIG: rd_data = ev_dig;
         `CSIM_IDX_EV_HIST: rd_data = ev_hist;
         `CSIM_IDX_MASK_LOOP: rd_data = mask_loop;
         `CSIM_IDX_MASK_SYS: rd_data = mask_sys;
         `CSIM_IDX_MASK_DIG: rd_data = mask_dig;
         `CSIM_IDX_MASK_HIST: rd_data = mask_hist;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         hrdata_o <= 32'h0000_0000;
      // upper and reserved bits read zero
      else if (addr_ok && !hwrite_i)
         hrdata_o <= {24'h00_0000, rd_data};
   end

endmodule // csim_monitor

// File: verif/csim_monitor_chk.sv
`timescale 1ns/10ps
`include "csim_map.svh"
module csim_monitor_chk
   import csim_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // bus
   input wire logic hsel_i,
   input wire logic [17:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // events
   input wire csim_pulses_s pulses_i
);
   logic rd;
   logic [15:0] idx;
   assign rd = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
   assign idx = haddr_i[17:2];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////////
   AST_READY: assert property (hreadyout_o)
      else $error("wait state inserted");
   AST_OKAY: assert property (!hresp_o)
      else $error("error response");
   AST_UPPER: assert property (hrdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   AST_HOLD: assert property (!rd |=> $stable(hrdata_o))
      else $error("read data moved without a read");
   AST_ST_RSVD: assert property (rd && idx == `CSIM_IDX_STATUS |=> !hrdata_o[7])
      else $error("status bit 7 set");
   AST_BOTH: assert property (rd && idx == `CSIM_IDX_STATUS |=> !hrdata_o[6] || hrdata_o[2])
      else $error("both-locked without output loop lock");
   AST_ALL: assert property (rd && idx == `CSIM_IDX_STATUS
      |=> !hrdata_o[5] || (hrdata_o[6] && hrdata_o[0]))
      else $error("all-locked inconsistent");
   AST_LOOP_RSVD: assert property (rd && idx == `CSIM_IDX_EV_LOOP |=> hrdata_o[7:6] == 2'b00)
      else $error("loop event reserved bits set");
   AST_HIST_RSVD: assert property (rd && (idx == `CSIM_IDX_EV_SYS || idx == `CSIM_IDX_EV_HIST)
      |=> hrdata_o[7:5] == 3'b000)
      else $error("event reserved bits set");
   AST_CLR_WO: assert property (rd && idx == `CSIM_IDX_CLR_LOOP |=> hrdata_o == 32'h0000_0000)
      else $error("clear register reads nonzero");
   COV_HIST: cover property (pulses_i.history_update);
   COV_STAT: cover property (rd && idx == `CSIM_IDX_STATUS);
   COV_DIG: cover property (rd && idx == `CSIM_IDX_EV_DIG);
endmodule // csim_monitor_chk

bind csim_monitor csim_monitor_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .pulses_i(pulses_i));

// File: verif/csim_monitor_tb.sv
`timescale 1ns/10ps
`include "csim_map.svh"
module csim_monitor_tb
   import csim_pkg::*;
;
   logic sys_clk_i;
   logic sys_rst_i = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready;
   logic [1:0] htrans = 2'b00;
   logic [17:0] haddr = 18'h0_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] rv;
   csim_levels_s lv = '0;
   csim_pulses_s pl = '0;
   logic [7:0] ev [4];
   logic [7:0] msk [4] = '{default: 8'h00};
   logic [9:0] pv, r, f, p;
   logic [7:0] snap;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   csim_monitor dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(), .levels_i(lv), .pulses_i(pl));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   // sticky unmasked events
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         test_done();
      end
      if (sys_rst_i)
      begin
         ev = '{default: 8'h00};
         pv = 10'h000;
      end
      else
      begin
         r = lv & ~pv;
         f = ~lv & pv;
         p = pl;
         ev[0] = ev[0] | ({2'b00, f[9], r[9], f[7], r[7], f[6], r[6]} & ~msk[0]);
         ev[1] = ev[1] | ({3'b000, p[9:5]} & ~msk[1]);
         ev[2] = ev[2] | ({p[4:1], f[3], r[3], f[2], r[2]} & ~msk[2]);
         ev[3] = ev[3] | ({3'b000, p[0], f[1], r[1], f[0], r[0]} & ~msk[3]);
         pv = lv;
      end
   end
   function automatic logic [7:0] st(input logic [9:0] l);
      return {1'b0, l[4] & l[7], l[9] & l[7] & l[4], l[5], l[6], l[7], l[8], l[9]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge sys_clk_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {idx, 2'b00};
      @(posedge sys_clk_i);
      while (hready !== 1'b1) @(posedge sys_clk_i);
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge sys_clk_i);
      while (hready !== 1'b1) @(posedge sys_clk_i);
      rv = hrdata;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(rv, {24'h00_0000, exp});
   endtask
   task automatic evchk();
      for (int i = 0; i < 4; i++)
         rdchk(`CSIM_IDX_EV_LOOP + 16'(i), ev[i]);
   endtask
   task automatic test_done();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h9cdf));
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      evchk();
      for (int i = 0; i < 4; i++)
         rdchk(`CSIM_IDX_MASK_LOOP + 16'(i), 8'h00);
      rdchk(`CSIM_IDX_STATUS, 8'h00);
      rdchk(16'h0D06, 8'h00);
      rdchk(`CSIM_IDX_CLR_LOOP, 8'h00);
      $display("test reset done");
      for (int b = 0; b < 10; b++)
      begin
         pl <= csim_pulses_s'(10'h001 << b);
         @(posedge sys_clk_i);
         pl <= '0;
         repeat (2) @(posedge sys_clk_i);
         // a second read shows that reading leaves bits set
         evchk();
         evchk();
      end
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, `CSIM_IDX_CLR_LOOP + 16'(i), 8'hFF);
         ev[i] = 8'h00;
      end
      evchk();
      $display("test pulses done");
      repeat (40)
      begin
         lv <= 10'($urandom);
         repeat (2) @(posedge sys_clk_i);
         xfer(1'b1, `CSIM_IDX_UPDATE, `CSIM_UPDATE_VAL);
         snap = st(lv);
         xfer(1'b1, `CSIM_IDX_STATUS, 8'hFF);
         rdchk(`CSIM_IDX_STATUS, snap);
         evchk();
      end
      xfer(1'b1, `CSIM_IDX_CLR_ALL, 8'h02);
      ev = '{default: 8'h00};
      evchk();
      $display("test levels done");
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, `CSIM_IDX_MASK_LOOP + 16'(i), 8'hFF);
         msk[i] = 8'hFF;
      end
      repeat (20)
      begin
         lv <= 10'($urandom);
         pl <= 10'($urandom);
         @(posedge sys_clk_i);
      end
      pl <= '0;
      repeat (2) @(posedge sys_clk_i);
      evchk();
      $display("test mask done");
      test_done();
   end
endmodule // csim_monitor_tb
